/* rtl/prpd_pkg.sv */
// Constants and types for the register/port pointer decode block.
// Assumes a single 25 MHz clock with a synchronous active-high reset.
// Overview of operation
// RULE1: Select 0000 reads common status register
// RULE2: Select 0001 writes common control register
// RULE3: Select 0010 writes port control register one
// RULE4: Select 0011 writes port control register two
// RULE5: Select 0100 reads port status register one
// RULE6: Select 0101 reads port status register two
// RULE7: Selects 0110/0111 read resistance low/high byte
// RULE8: Selects 1000/1001 read voltage low/high byte
// RULE9: Selects 1010/1011 read current low/high byte
// RULE10: Selects 1100/1101 read temperature low/high byte
// RULE11: Select 1111 writes common test register
// RULE12: Pointer bits 1:0 pick port one to four
// RULE13: Common writes hit all ports, others one
// RULE14: Latch pointer after eighth bit, then acknowledge
// RULE15: Bits 7 and 2 ignored; pointer resets zero
// RULE16: Select 1110 reads zero, ignores writes
package prpd_pkg;

   // ==========================================
   // Pointer fields
   localparam int SEL_MSB = 6;
   localparam int SEL_LSB = 3;
   localparam int PORT_MSB = 1;
   localparam int PORT_LSB = 0;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_USED_MASK = 8'h7b;

   // ==========================================
   // Register select codes
   localparam logic [3:0] SEL_COMMON_STAT = 4'h0;
   localparam logic [3:0] SEL_COMMON_CTRL = 4'h1;
   localparam logic [3:0] SEL_PORT_CTRL1 = 4'h2;
   localparam logic [3:0] SEL_PORT_CTRL2 = 4'h3;
   localparam logic [3:0] SEL_PORT_STAT1 = 4'h4;
   localparam logic [3:0] SEL_PORT_STAT2 = 4'h5;
   localparam logic [3:0] SEL_RES_LO = 4'h6;
   localparam logic [3:0] SEL_RES_HI = 4'h7;
   localparam logic [3:0] SEL_VOLT_LO = 4'h8;
   localparam logic [3:0] SEL_VOLT_HI = 4'h9;
   localparam logic [3:0] SEL_CURR_LO = 4'ha;
   localparam logic [3:0] SEL_CURR_HI = 4'hb;
   localparam logic [3:0] SEL_TEMP_LO = 4'hc;
   localparam logic [3:0] SEL_TEMP_HI = 4'hd;
   localparam logic [3:0] SEL_RESERVED = 4'he;
   localparam logic [3:0] SEL_TEST = 4'hf;

   // ==========================================
   // Port masks and serial framing
   localparam logic [3:0] MASK_ALL = 4'hf;
   localparam logic [3:0] MASK_ONE = 4'h1;
   localparam int DEV_ADDR_MSB = 5;
   localparam int DEV_ADDR_LSB = 1;
   localparam int RW_BIT = 0;
   localparam logic [3:0] BITS_FULL = 4'h8;
   localparam logic [3:0] TX_LAST = 4'h7;
   localparam logic SDA_DRIVE_LEVEL = 1'b0;

   // ==========================================
   // Types
   typedef struct packed {
      logic [7:0] status1;
      logic [7:0] status2;
      logic [15:0] res;
      logic [15:0] volt;
      logic [15:0] curr;
   } prpd_port_rd_type;

   typedef struct packed {
      logic common_ctrl;
      logic port_ctrl1;
      logic port_ctrl2;
      logic test;
   } prpd_wsel_type;

   typedef struct packed {
      prpd_wsel_type sel;
      logic [3:0] port_mask;
      logic [7:0] data;
   } prpd_wr_type;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } prpd_state_type;

endpackage

/* rtl/prpd_ptr_decode.sv */
// Pointer decode: write target, port mask and read byte selection.
// Assumes all read sources are stable on the system clock.
module prpd_ptr_decode (
   // Pointer
   input wire logic [7:0] ptr,
   // Read sources
   input wire logic [3:0] port_fault,
   input wire logic [1:0] chip_rev,
   input wire logic [1:0] chip_id,
   input wire prpd_pkg::prpd_port_rd_type [3:0] port_rd,
   input wire logic [15:0] temp_result,
   // Decoded
   output prpd_pkg::prpd_wsel_type wsel,
   output logic [3:0] port_mask,
   output logic [7:0] rd_byte
);

   logic [3:0] sel;
   logic [1:0] port;
   prpd_pkg::prpd_port_rd_type pr;

   always_comb begin
      sel = ptr[prpd_pkg::SEL_MSB:prpd_pkg::SEL_LSB];
      port = ptr[prpd_pkg::PORT_MSB:prpd_pkg::PORT_LSB];
      pr = port_rd[port]; // RULE12
      wsel = '0;
      port_mask = '0;
      rd_byte = '0;
      case (sel)
         prpd_pkg::SEL_COMMON_STAT: rd_byte = {port_fault, chip_rev, chip_id}; // RULE1
         prpd_pkg::SEL_COMMON_CTRL: begin
            wsel.common_ctrl = 1'b1; // RULE2
            port_mask = prpd_pkg::MASK_ALL; // RULE13
         end
         prpd_pkg::SEL_PORT_CTRL1: begin
            wsel.port_ctrl1 = 1'b1; // RULE3
            port_mask = prpd_pkg::MASK_ONE << port; // RULE13
         end
         prpd_pkg::SEL_PORT_CTRL2: begin
            wsel.port_ctrl2 = 1'b1; // RULE4
            port_mask = prpd_pkg::MASK_ONE << port;
         end
         prpd_pkg::SEL_PORT_STAT1: rd_byte = pr.status1; // RULE5
         prpd_pkg::SEL_PORT_STAT2: rd_byte = pr.status2; // RULE6
         prpd_pkg::SEL_RES_LO: rd_byte = pr.res[7:0]; // RULE7
         prpd_pkg::SEL_RES_HI: rd_byte = pr.res[15:8]; // RULE7
         prpd_pkg::SEL_VOLT_LO: rd_byte = pr.volt[7:0]; // RULE8
         prpd_pkg::SEL_VOLT_HI: rd_byte = pr.volt[15:8]; // RULE8
         prpd_pkg::SEL_CURR_LO: rd_byte = pr.curr[7:0]; // RULE9
         prpd_pkg::SEL_CURR_HI: rd_byte = pr.curr[15:8]; // RULE9
         prpd_pkg::SEL_TEMP_LO: rd_byte = temp_result[7:0]; // RULE10
         prpd_pkg::SEL_TEMP_HI: rd_byte = temp_result[15:8]; // RULE10
         prpd_pkg::SEL_TEST: begin
            wsel.test = 1'b1; // RULE11
            port_mask = prpd_pkg::MASK_ALL;
         end
         // Reserved select and write-only reads return zero
         default: rd_byte = '0; // RULE16
      endcase
   end

endmodule

/* rtl/prpd_sync.sv */
// Two-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a slow level; no bus coherency across bits.
module prpd_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            meta_q[i] <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            meta_q[i] <= d[i];
            q[i] <= meta_q[i];
         end
      end
   end

endmodule

/* rtl/prpd_top.sv */
// Serial target front end holding the register/port pointer.
// Assumes scl, sda_in and address straps are asynchronous pins;
// fault and result inputs come from logic on clk_sys.
module prpd_top #(
   // Arbitrary value, identity of the part
   parameter logic [1:0] CHIP_ID = 2'h1,
   // Arbitrary value, silicon revision
   parameter logic [1:0] CHIP_REV = 2'h0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Serial pins
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Device address straps
   input wire logic [4:0] addr_pins,
   // Read sources
   input wire logic [3:0] port_fault,
   input wire prpd_pkg::prpd_port_rd_type [3:0] port_rd,
   input wire logic [15:0] temp_result,
   // Write strobe and pointer state
   output prpd_pkg::prpd_wr_type wr_out,
   output logic [7:0] pointer_out
);

   // ==========================================
   // Pin synchronisation
   logic [6:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic [4:0] addr_s;

   prpd_sync #(
      .WIDTH(7)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d({addr_pins, sda_in, scl}),
      .q(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign addr_s = pins_s[6:2];

   // ==========================================
   // Edge and framing detection
   logic scl_p_q;
   logic sda_p_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_p_q <= 1'b0;
         sda_p_q <= 1'b0;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   // Data edges only count while clock is steadily high
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ==========================================
   // Pointer decode
   prpd_pkg::prpd_state_type state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic rw_q, rw_d;
   logic [7:0] ptr_q, ptr_d;
   logic oe_q, oe_d;
   logic sda_out_q;
   prpd_pkg::prpd_wr_type wr_q, wr_d;
   prpd_pkg::prpd_wsel_type wsel;
   logic [3:0] port_mask;
   logic [7:0] rd_byte;
   logic rx_state;
   logic byte_done;
   logic wr_fire;
   logic [3:0] sel_w;
   logic [1:0] port_w;

   prpd_ptr_decode u_decode (
      .ptr(ptr_q),
      .port_fault(port_fault),
      .chip_rev(CHIP_REV),
      .chip_id(CHIP_ID),
      .port_rd(port_rd),
      .temp_result(temp_result),
      .wsel(wsel),
      .port_mask(port_mask),
      .rd_byte(rd_byte)
   );

   assign sel_w = ptr_q[prpd_pkg::SEL_MSB:prpd_pkg::SEL_LSB];
   assign port_w = ptr_q[prpd_pkg::PORT_MSB:prpd_pkg::PORT_LSB];
   assign rx_state = (state_q == prpd_pkg::ST_ADDR) || (state_q == prpd_pkg::ST_PTR)
                     || (state_q == prpd_pkg::ST_WDATA);
   assign byte_done = (cnt_q == prpd_pkg::BITS_FULL);
   assign wr_fire = scl_fall && (state_q == prpd_pkg::ST_WDATA) && byte_done;

   // ==========================================
   // Serial target sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      rw_d = rw_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      wr_d = '0;
      if (start_det) begin
         // Repeated start is legal from any state
         state_d = prpd_pkg::ST_ADDR;
         cnt_d = '0;
         oe_d = 1'b1;
      end else if (stop_det) begin
         state_d = prpd_pkg::ST_IDLE;
         oe_d = 1'b1;
      end else if (scl_rise && rx_state) begin
         shift_d = {shift_q[6:0], sda_s};
         cnt_d = cnt_q + 4'h1;
      end else if (scl_fall) begin
         case (state_q)
            prpd_pkg::ST_ADDR: begin
               if (byte_done) begin
                  // Top two address bits are not compared
                  if (shift_q[prpd_pkg::DEV_ADDR_MSB:prpd_pkg::DEV_ADDR_LSB] == addr_s) begin
                     state_d = prpd_pkg::ST_ADDR_ACK;
                     rw_d = shift_q[prpd_pkg::RW_BIT];
                     oe_d = 1'b0;
                  end else begin
                     state_d = prpd_pkg::ST_IDLE;
                  end
               end
            end
            prpd_pkg::ST_PTR: begin
               if (byte_done) begin
                  ptr_d = shift_q & prpd_pkg::PTR_USED_MASK; // RULE14 RULE15
                  state_d = prpd_pkg::ST_PTR_ACK;
                  oe_d = 1'b0; // RULE14
               end
            end
            prpd_pkg::ST_WDATA: begin
               if (byte_done) begin
                  // Reserved and read-only selects raise no strobe at all
                  if (wsel != '0) begin // RULE16
                     wr_d = {wsel, port_mask, shift_q}; // RULE13
                  end
                  state_d = prpd_pkg::ST_WDATA_ACK;
                  oe_d = 1'b0;
               end
            end
            prpd_pkg::ST_ADDR_ACK: begin
               cnt_d = '0;
               if (rw_q) begin
                  state_d = prpd_pkg::ST_RDATA;
                  shift_d = rd_byte;
                  oe_d = rd_byte[7];
               end else begin
                  state_d = prpd_pkg::ST_PTR;
                  oe_d = 1'b1;
               end
            end
            prpd_pkg::ST_PTR_ACK: begin
               state_d = prpd_pkg::ST_WDATA;
               cnt_d = '0;
               oe_d = 1'b1;
            end
            prpd_pkg::ST_RDATA: begin
               if (cnt_q == prpd_pkg::TX_LAST) begin
                  state_d = prpd_pkg::ST_RDATA_ACK;
                  oe_d = 1'b1;
               end else begin
                  shift_d = {shift_q[6:0], 1'b0};
                  oe_d = shift_q[6];
                  cnt_d = cnt_q + 4'h1;
               end
            end
            prpd_pkg::ST_WDATA_ACK, prpd_pkg::ST_RDATA_ACK: begin
               // One byte per frame; extra bytes wait for a new start
               state_d = prpd_pkg::ST_IDLE;
               oe_d = 1'b1;
            end
            default: state_d = prpd_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= prpd_pkg::ST_IDLE;
         cnt_q <= '0;
         shift_q <= '0;
         rw_q <= 1'b0;
         ptr_q <= prpd_pkg::PTR_RESET; // RULE15
         oe_q <= 1'b1;
         sda_out_q <= prpd_pkg::SDA_DRIVE_LEVEL;
         wr_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         rw_q <= rw_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         sda_out_q <= prpd_pkg::SDA_DRIVE_LEVEL;
         wr_q <= wr_d;
      end
   end

   assign sda_out = sda_out_q;
   assign sda_oe_n = oe_q;
   assign wr_out = wr_q;
   assign pointer_out = ptr_q;

   // ==========================================
   // Assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_common_status: assert property ( // RULE1
      (sel_w == prpd_pkg::SEL_COMMON_STAT) |-> rd_byte == {port_fault, CHIP_REV, CHIP_ID})
      else $error("common status read byte wrong");

   a_ctrl_write: assert property ( // RULE2
      (wr_fire && sel_w == prpd_pkg::SEL_COMMON_CTRL)
      |=> wr_q.sel.common_ctrl && wr_q.port_mask == 4'hf && wr_q.data == $past(shift_q))
      else $error("common control write strobe wrong");

   a_pctrl1_write: assert property ( // RULE3
      (wr_fire && sel_w == prpd_pkg::SEL_PORT_CTRL1)
      |=> wr_q.sel.port_ctrl1 && wr_q.port_mask == (4'h1 << $past(port_w)))
      else $error("port control one strobe wrong");

   a_pctrl2_write: assert property ( // RULE4
      (wr_fire && sel_w == prpd_pkg::SEL_PORT_CTRL2)
      |=> wr_q.sel.port_ctrl2 && !wr_q.sel.port_ctrl1 && $countones(wr_q.port_mask) == 1)
      else $error("port control two strobe wrong");

   a_stat1_read: assert property ( // RULE5
      (sel_w == prpd_pkg::SEL_PORT_STAT1) |-> rd_byte == port_rd[port_w].status1)
      else $error("port status one read wrong");

   a_stat2_read: assert property ( // RULE6
      (sel_w == prpd_pkg::SEL_PORT_STAT2) |-> rd_byte == port_rd[port_w].status2)
      else $error("port status two read wrong");

   a_res_bytes: assert property ( // RULE7
      (sel_w == 4'h6 || sel_w == 4'h7)
      |-> rd_byte == (sel_w[0] ? port_rd[port_w].res[15:8] : port_rd[port_w].res[7:0]))
      else $error("resistance byte wrong");

   a_volt_bytes: assert property ( // RULE8
      (sel_w == 4'h8 || sel_w == 4'h9)
      |-> rd_byte == (sel_w[0] ? port_rd[port_w].volt[15:8] : port_rd[port_w].volt[7:0]))
      else $error("voltage byte wrong");

   a_curr_bytes: assert property ( // RULE9
      (sel_w == 4'ha || sel_w == 4'hb)
      |-> rd_byte == (sel_w[0] ? port_rd[port_w].curr[15:8] : port_rd[port_w].curr[7:0]))
      else $error("current byte wrong");

   a_temp_bytes: assert property ( // RULE10
      (sel_w == 4'hc || sel_w == 4'hd)
      |-> rd_byte == (sel_w[0] ? temp_result[15:8] : temp_result[7:0]))
      else $error("temperature byte wrong");

   a_test_write: assert property ( // RULE11
      (wr_fire && sel_w == prpd_pkg::SEL_TEST) |=> wr_q.sel.test && wr_q.port_mask == 4'hf)
      else $error("test register strobe wrong");

   a_port_field: assert property ( // RULE12
      (sel_w == prpd_pkg::SEL_PORT_STAT1 && port_w == 2'h3) |-> rd_byte == port_rd[3].status1)
      else $error("port field selects wrong port");

   a_mask_scope: assert property ( // RULE13
      (wr_q.sel.common_ctrl || wr_q.sel.test) |-> wr_q.port_mask == 4'hf
      ##1 (wr_q == '0))
      else $error("common write mask or pulse length wrong");

   a_ptr_latch: assert property ( // RULE14
      (scl_fall && state_q == prpd_pkg::ST_PTR && byte_done && !start_det && !stop_det)
      |=> ptr_q == ($past(shift_q) & 8'h7b) && !sda_oe_n && state_q == prpd_pkg::ST_PTR_ACK)
      else $error("pointer not latched and acknowledged");

   a_ptr_unused: assert property ( // RULE15
      !ptr_q[7] && !ptr_q[2] && ($fell(rst) -> ptr_q == 8'h00))
      else $error("unused pointer bit set or bad reset");

   a_reserved_sel: assert property ( // RULE16
      (wr_fire && sel_w == prpd_pkg::SEL_RESERVED) |-> rd_byte == 8'h00 ##1 wr_q == '0)
      else $error("reserved select not inert");

endmodule

/* verification/prpd_host.sv */
// Host model that frames bytes on the serial clock and data lines.
// Assumes an open-drain data wire with a pull-up, resolved by the bench.
module prpd_host (
   // Clock
   input wire logic clk_sys,
   // Serial lines
   output logic scl,
   output logic sda,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ns;

   // Quarter bit time in clk_sys; raise it for a slow host
   int quarter = 3;

   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // ==========================================
   // Bus phases
   task automatic tick();
      repeat (quarter) @(posedge clk_sys);
      #1;
   endtask

   // Also serves as repeated start
   task automatic start();
      sda = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      tick();
      sda = 1'b0;
      tick();
      tick();
      scl = 1'b0;
   endtask

   task automatic stop();
      tick();
      sda = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      tick();
      sda = 1'b1;
      tick();
      tick();
   endtask

   // Data moves only while scl is low; the target is read at mid-high
   task automatic bit_xfer(input logic b, output logic r);
      tick();
      sda = b;
      tick();
      scl = 1'b1;
      tick();
      r = sda_line;
      tick();
      scl = 1'b0;
   endtask

   // MSB first; send 8'hff to read, ack is the ninth bit
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], q[i]);
      end
      bit_xfer(1'b1, ack);
   endtask
endmodule

/* verification/tb_port_register_pointer_decode.sv */
// Self-checking bench for the register/port pointer decode block.
// Assumes the host model in prpd_host.sv and the design package.
module tb_port_register_pointer_decode;
   timeunit 1ns;
   timeprecision 1ns;

   // Arbitrary identity values
   localparam logic [1:0] T_ID = 2'h3;
   localparam logic [1:0] T_REV = 2'h2;
   localparam logic [4:0] PINS = 5'h0b;
   localparam logic [7:0] ADDR_W = {2'b10, PINS, 1'b0};
   localparam logic [7:0] ADDR_R = {2'b01, PINS, 1'b1};

   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic scl;
   logic sda_host;
   logic sda_out;
   logic sda_oe_n;
   logic [4:0] addr_pins = PINS;
   logic [3:0] port_fault = 4'ha;
   prpd_pkg::prpd_port_rd_type [3:0] port_rd;
   logic [15:0] temp_result = 16'h9a95;
   prpd_pkg::prpd_wr_type wr_out;
   prpd_pkg::prpd_wr_type wr_seen;
   logic [7:0] pointer_out;
   int error_cnt = 0;
   int n_compared = 0;
   int wr_pulses = 0;
   // Pull-up wire: low when either party pulls it
   wire sda_line = sda_host & (sda_oe_n | sda_out);

   always #20 clk_sys = ~clk_sys;

   prpd_top #(.CHIP_ID(T_ID), .CHIP_REV(T_REV)) i_prpd_top (
      .clk_sys(clk_sys), .rst(rst), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_pins(addr_pins),
      .port_fault(port_fault), .port_rd(port_rd), .temp_result(temp_result),
      .wr_out(wr_out), .pointer_out(pointer_out));

   prpd_host i_prpd_host (.clk_sys(clk_sys), .scl(scl), .sda(sda_host), .sda_line(sda_line));

   // Strobe watcher: a wider pulse shows up as an extra count
   always @(posedge clk_sys) begin
      if (wr_out !== '0) begin
         wr_seen = wr_out;
         wr_pulses++;
      end
   end

   // ==========================================
   // Helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send(input logic [7:0] d, input logic exp_ack);
      logic [7:0] q;
      logic ack;
      i_prpd_host.xfer(d, q, ack);
      check("ack", {15'h0, ack}, {15'h0, exp_ack});
   endtask

   task automatic put_ptr(input logic [7:0] ptr, input logic [7:0] d, input logic with_data);
      i_prpd_host.start();
      send(ADDR_W, 1'b0);
      send(ptr, 1'b0);
      if (with_data) begin
         send(d, 1'b0);
      end
      i_prpd_host.stop();
   endtask

   task automatic get_byte(output logic [7:0] q);
      logic ack;
      i_prpd_host.start();
      send(ADDR_R, 1'b0);
      i_prpd_host.xfer(8'hff, q, ack);
      i_prpd_host.stop();
   endtask

   function automatic prpd_pkg::prpd_wr_type exp_wr(input logic [3:0] s, input logic [1:0] p,
         input logic [7:0] d);
      prpd_pkg::prpd_wr_type w;
      w = '0;
      w.data = d;
      w.port_mask = (s == 4'h1 || s == 4'hf) ? 4'hf : 4'h1 << p;
      case (s)
         4'h1: w.sel.common_ctrl = 1'b1;
         4'h2: w.sel.port_ctrl1 = 1'b1;
         4'h3: w.sel.port_ctrl2 = 1'b1;
         4'hf: w.sel.test = 1'b1;
         default: w = '0;
      endcase
      return w;
   endfunction

   function automatic logic [7:0] exp_rd(input logic [3:0] s, input logic [1:0] p);
      prpd_pkg::prpd_port_rd_type r;
      r = port_rd[p];
      case (s)
         4'h0: return {port_fault, T_REV, T_ID};
         4'h4: return r.status1;
         4'h5: return r.status2;
         4'h6: return r.res[7:0];
         4'h7: return r.res[15:8];
         4'h8: return r.volt[7:0];
         4'h9: return r.volt[15:8];
         4'ha: return r.curr[7:0];
         4'hb: return r.curr[15:8];
         4'hc: return temp_result[7:0];
         4'hd: return temp_result[15:8];
         default: return 8'h00;
      endcase
   endfunction

   // ==========================================
   // Scenarios
   task automatic t_reset();
      check("pointer_out", {8'h00, pointer_out}, 16'h0000);
      check("wr_out", wr_out, 16'h0000);
      check("sda_oe_n", {15'h0, sda_oe_n}, 16'h0001);
      check("sda_out", {15'h0, sda_out}, 16'h0000);
      $display("test reset done");
   endtask

   // Unused pointer bits are sent as ones to prove they are dropped
   task automatic t_writes();
      logic [3:0] s;
      logic [1:0] p;
      prpd_pkg::prpd_wr_type e;
      for (int i = 0; i < 16; i++) begin
         s = 4'(i);
         p = s[1:0] ^ s[3:2];
         e = exp_wr(s, p, {s, ~s});
         wr_pulses = 0;
         wr_seen = '0;
         put_ptr({1'b1, s, 1'b1, p}, {s, ~s}, 1'b1);
         check("pointer_out", {8'h00, pointer_out}, {9'h0, s, 1'b0, p});
         check("wr_pulses", 16'(wr_pulses), (e !== '0) ? 16'h1 : 16'h0);
         check("wr_out", wr_seen, e);
      end
      $display("test writes done");
   endtask

   task automatic t_reads();
      logic [7:0] q;
      for (int i = 0; i < 64; i++) begin
         put_ptr({1'b1, 4'(i / 4), 1'b1, 2'(i)}, 8'h00, 1'b0);
         get_byte(q);
         check("rd_byte", {8'h00, q}, {8'h00, exp_rd(4'(i / 4), 2'(i))});
      end
      $display("test reads done");
   endtask

   // Foreign address: no ack, later bytes ignored, pointer kept
   task automatic t_refuse();
      wr_pulses = 0;
      i_prpd_host.start();
      send(ADDR_W ^ 8'h04, 1'b1);
      send(8'h08, 1'b1);
      send(8'h55, 1'b1);
      i_prpd_host.stop();
      check("pointer_out", {8'h00, pointer_out}, 16'h007b);
      check("wr_pulses", 16'(wr_pulses), 16'h0000);
      $display("test refuse done");
   endtask

   task automatic t_slow_reset();
      i_prpd_host.quarter = 6;
      wr_seen = '0;
      put_ptr(8'h1b, 8'hc3, 1'b1);
      i_prpd_host.quarter = 3;
      check("wr_out", wr_seen, exp_wr(4'h3, 2'h3, 8'hc3));
      @(posedge clk_sys);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      check("pointer_out", {8'h00, pointer_out}, 16'h0000);
      repeat (6) @(posedge clk_sys);
      $display("test slow and reset done");
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      for (int p = 0; p < 4; p++) begin
         port_rd[p] = {8'h40 + 8'(p), 8'h50 + 8'(p), 16'h6160 + 16'(p), 16'h7170 + 16'(p),
            16'h8180 + 16'(p)};
      end
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      t_reset();
      t_writes();
      t_reads();
      t_refuse();
      t_slow_reset();
      conclude();
   end

   // About 40k cycles expected; limit at 60k cycles
   initial begin
      #2400us;
      error_cnt++;
      conclude();
   end
endmodule
